// File: verilog/aiq_pkg.sv
// Package of constants and types for the injected queue control block
package aiq_pkg;
  // Register offsets (byte addresses, one word each)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CFG = 8'h04;
  localparam logic [7:0] ADDR_JSEQ = 8'h08;
  localparam logic [7:0] ADDR_COMMON = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h14;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h18;
  localparam logic [7:0] ADDR_THRESH = 8'h1c;
  localparam logic [7:0] ADDR_JRES0 = 8'h20;
  localparam logic [7:0] ADDR_REGRES = 8'h30;
  localparam logic [7:0] ADDR_ID = 8'h34;
  // Control bits
  localparam int CTRL_JSTART_BIT = 0;
  localparam int CTRL_JSTOP_BIT = 1;
  // Config bits
  localparam int CFG_QDIS_BIT = 0;
  localparam int CFG_QMODE_BIT = 1;
  localparam int CFG_OVERRUN_MODE_SELECT_BIT = 2;
  localparam int CFG_GUARD_LSB = 8;
  // Injected sequence register fields
  localparam int JSEQ_LEN_LSB = 0;
  localparam int JSEQ_TSEL_LSB = 2;
  localparam int JSEQ_TPOL_LSB = 6;
  localparam int JSEQ_CH_LSB = 8;
  // Status bits
  localparam int ST_INJECTED_SEQUENCE_END_FLAG_BIT = 0;
  localparam int ST_AWD_BIT = 1;
  localparam int ST_QEMPTY_BIT = 2;
  localparam int ST_OVR_BIT = 3;
  localparam int NUM_EVENTS = 4;
  // Dual mode codes
  localparam logic [4:0] DUAL_INTL_SIMINJ = 5'h03;
  localparam logic [4:0] DUAL_INTL_ONLY = 5'h07;
  // Reset values
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] JSEQ_RESET = 32'h0000_0000;
  localparam logic [31:0] THRESH_RESET = 32'hffff_0000;
  // Identity value, arbitrary
  localparam logic [31:0] ID_VALUE = 32'h0000_a5c3;
  localparam int QDEPTH = 2;
  localparam int RES_W = 16;

  typedef enum logic [1:0] {
    AIQ_IDLE = 2'b00,
    AIQ_WAIT = 2'b01,
    AIQ_CONV = 2'b11,
    AIQ_DONE = 2'b10
  } aiq_state_t;
endpackage : aiq_pkg

// File: verilog/aiq_conv_if.sv
// Interface between sequencer and the conversion core side
`timescale 1ns/10ps
interface aiq_conv_if;
  logic start;
  logic [4:0] chan;
  logic injected;
  logic eoc;
  logic [15:0] data;
  modport seq (output start, output chan, output injected,
               input eoc, input data);
  modport core (input start, input chan, input injected,
                output eoc, output data);
endinterface : aiq_conv_if

// File: verilog/aiq_ctx_queue.sv
// Two-entry context queue for injected sequence settings
`timescale 1ns/10ps
module aiq_ctx_queue (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Push side
  input wire logic push,
  input wire logic [31:0] push_ctx,
  // Consume side
  input wire logic pop,
  input wire logic keep_last,
  // State
  output logic [31:0] head_ctx,
  output logic empty,
  output logic full
);
  logic [31:0] mem_q [aiq_pkg::QDEPTH];
  logic [1:0] cnt_q;
  logic do_pop;
  logic stale_q;
  logic retire;

  // Keep last context when queue would run dry
  assign do_pop = pop && (cnt_q != 2'd0) && !(keep_last && cnt_q == 2'd1);
  // Kept context is used up: a new write takes its slot, never queues behind
  assign retire = stale_q || (pop && keep_last && cnt_q == 2'd1);
  assign empty = (cnt_q == 2'd0);
  assign full = (cnt_q == 2'(aiq_pkg::QDEPTH));
  assign head_ctx = mem_q[0];

  // Ordered storage, shift on consume; full write overwrites tail
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= 2'd0;
      stale_q <= 1'b0;
      mem_q[0] <= aiq_pkg::JSEQ_RESET;
      mem_q[1] <= aiq_pkg::JSEQ_RESET;
    end else begin
      if (do_pop) begin
        mem_q[0] <= mem_q[1];
      end
      if (push) begin
        if (do_pop) begin
          mem_q[(cnt_q == 2'd2) ? 1 : 0] <= push_ctx;
        end else if (retire || cnt_q == 2'd0) begin
          mem_q[0] <= push_ctx;
        end else begin
          mem_q[1] <= push_ctx;
        end
      end
      if (push && !do_pop && !retire && cnt_q != 2'd2) begin
        cnt_q <= cnt_q + 2'd1;
      end else if (do_pop && !push) begin
        cnt_q <= cnt_q - 2'd1;
      end
      // Used-up last context stays as head until a write replaces it
      if (push || do_pop) begin
        stale_q <= 1'b0;
      end else if (retire) begin
        stale_q <= 1'b1;
      end
    end
  end
endmodule : aiq_ctx_queue

// File: verilog/aiq_watchdog.sv
// Analog watchdog output flag
`timescale 1ns/10ps
module aiq_watchdog (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Conversion result
  input wire logic eoc,
  input wire logic guarded,
  input wire logic [15:0] data,
  input wire logic [31:0] thresh,
  // Flag
  output logic awd_q
);
  logic outside;

  // Low threshold in low half, high threshold in high half
  assign outside = (data < thresh[15:0]) || (data > thresh[31:16]);

  // Only guarded conversions move the flag
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      awd_q <= 1'b0;
    end else if (eoc && guarded) begin
      awd_q <= outside;
    end
  end
endmodule : aiq_watchdog

// File: verilog/aiq_top.sv
// Injected queue control of a converter: registers, queue, sequencer
//
// Operation
// - Sequence end consumes queue, next uses latest
// - Queue active when disable bit clear; wait trigger
// - Queue mode 0 keeps last context
// - Each context runs separately, never merged
// - Dual codes 3, 7; no spurious regular start
// - Watchdog rises on guarded out-of-range result
// - Watchdog clears only on guarded in-range result
// - Stop command halts; results keep their rank
//
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/10ps
module aiq_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata_q,
  // Triggers from pins
  input wire logic [15:0] inj_trig_pin,
  input wire logic reg_trig_pin,
  // Conversion core
  output logic conv_start_q,
  output logic [4:0] conv_chan_q,
  output logic conv_inj_q,
  input wire logic conv_eoc,
  input wire logic [15:0] conv_data,
  // Status outputs
  output logic watchdog_out_signal,
  output logic irq_q
);
  //////////////////////////////////////////////////////////////////////////
  // Registers and pin sync
  logic [31:0] cfg_q;
  logic [31:0] common_q;
  logic [31:0] thresh_q;
  logic [3:0] irq_en_q;
  logic [3:0] status_q;
  logic [15:0] jres_q [4];
  logic [15:0] regres_q;
  logic [15:0] tsync1_q, tsync2_q, tprev_q;
  logic rsync1_q, rsync2_q, rprev_q;
  logic jrun_q;
  logic [1:0] rank_q;
  logic awd_q;
  aiq_pkg::aiq_state_t state_q;
  logic [31:0] ctx_q;
  logic [31:0] head_ctx;
  logic q_empty, q_full;
  logic seq_done, pop_req, trig_hit, reg_trig;
  logic [3:0] ev;
  logic stop_cmd;
  logic context_queue_disable, queue_mode_select, overrun_mode_select;
  logic [4:0] dual_mode;
  logic reg_pending_q;

  aiq_conv_if cif ();

  assign context_queue_disable = cfg_q[aiq_pkg::CFG_QDIS_BIT];
  assign queue_mode_select = cfg_q[aiq_pkg::CFG_QMODE_BIT];
  assign overrun_mode_select = cfg_q[aiq_pkg::CFG_OVERRUN_MODE_SELECT_BIT];
  assign dual_mode = common_q[4:0];
  assign stop_cmd = wr && addr == aiq_pkg::ADDR_CTRL
                    && wdata[aiq_pkg::CTRL_JSTOP_BIT];

  // Decode one field of a context word
  function automatic logic [4:0] ctx_chan(input logic [31:0] c,
                                          input logic [1:0] r);
    ctx_chan = c[aiq_pkg::JSEQ_CH_LSB + 6*r +: 5];
  endfunction : ctx_chan

  // Two-flop sync on external triggers before any edge logic
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tsync1_q <= 16'h0000;
      tsync2_q <= 16'h0000;
      tprev_q <= 16'h0000;
      rsync1_q <= 1'b0;
      rsync2_q <= 1'b0;
      rprev_q <= 1'b0;
    end else begin
      tsync1_q <= inj_trig_pin;
      tsync2_q <= tsync1_q;
      tprev_q <= tsync2_q;
      rsync1_q <= reg_trig_pin;
      rsync2_q <= rsync1_q;
      rprev_q <= rsync2_q;
    end
  end

  // Selected trigger edge of the active context, polarity applied
  always_comb begin
    logic [3:0] sel;
    logic [1:0] pol;
    logic now_l, was_l;
    sel = ctx_q[aiq_pkg::JSEQ_TSEL_LSB +: 4];
    pol = ctx_q[aiq_pkg::JSEQ_TPOL_LSB +: 2];
    now_l = tsync2_q[sel];
    was_l = tprev_q[sel];
    case (pol)
      2'b01: trig_hit = now_l && !was_l;
      2'b10: trig_hit = !now_l && was_l;
      2'b11: trig_hit = now_l != was_l;
      default: trig_hit = 1'b0;
    endcase
  end
  assign reg_trig = rsync2_q && !rprev_q;

  //////////////////////////////////////////////////////////////////////////
  // Software register writes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_q <= aiq_pkg::CFG_RESET;
      common_q <= 32'h0000_0000;
      thresh_q <= aiq_pkg::THRESH_RESET;
      irq_en_q <= 4'h0;
    end else if (wr) begin
      case (addr)
        aiq_pkg::ADDR_CFG: cfg_q <= wdata;
        aiq_pkg::ADDR_COMMON: common_q <= wdata;
        aiq_pkg::ADDR_THRESH: thresh_q <= wdata;
        aiq_pkg::ADDR_IRQ_EN: irq_en_q <= wdata[3:0];
        default: ;
      endcase
    end
  end

  // Queue: writes go in order; disabled queue is never consumed, so its head stays in use
  aiq_ctx_queue u_queue (
    .clk(clk),
    .rst_n(rst_n),
    .push(wr && addr == aiq_pkg::ADDR_JSEQ),
    .push_ctx(wdata),
    .pop(pop_req),
    .keep_last(!queue_mode_select),
    .head_ctx(head_ctx),
    .empty(q_empty),
    .full(q_full)
  );

  //////////////////////////////////////////////////////////////////////////
  // Injected sequencer
  assign seq_done = state_q == aiq_pkg::AIQ_CONV && cif.eoc
                    && rank_q == ctx_q[1:0];
  // Consume only at sequence end, never mid-sequence
  assign pop_req = seq_done && !context_queue_disable;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= aiq_pkg::AIQ_IDLE;
      ctx_q <= aiq_pkg::JSEQ_RESET;
      rank_q <= 2'd0;
      jrun_q <= 1'b0;
    end else begin
      case (state_q)
        aiq_pkg::AIQ_IDLE: begin
          // Stop wins over a start in the same cycle
          jrun_q <= !stop_cmd && (jrun_q || (wr && addr == aiq_pkg::ADDR_CTRL
                    && wdata[aiq_pkg::CTRL_JSTART_BIT]));
          if (jrun_q && !stop_cmd
              && (!q_empty || context_queue_disable)) begin
            // Context latched whole; a later write cannot merge
            ctx_q <= head_ctx;
            state_q <= aiq_pkg::AIQ_WAIT;
          end
        end
        aiq_pkg::AIQ_WAIT: begin
          if (stop_cmd) begin
            state_q <= aiq_pkg::AIQ_IDLE;
            jrun_q <= 1'b0;
          end else if (trig_hit) begin
            // New context only launches on its own trigger
            rank_q <= 2'd0;
            state_q <= aiq_pkg::AIQ_CONV;
          end else begin
            // Follow the head so a write after completion is what runs
            ctx_q <= head_ctx;
          end
        end
        aiq_pkg::AIQ_CONV: begin
          if (cif.eoc) begin
            if (seq_done) begin
              state_q <= aiq_pkg::AIQ_DONE;
            end else begin
              rank_q <= rank_q + 2'd1;
            end
          end
          if (stop_cmd) begin
            state_q <= aiq_pkg::AIQ_IDLE;
            jrun_q <= 1'b0;
          end
        end
        aiq_pkg::AIQ_DONE: begin
          state_q <= aiq_pkg::AIQ_IDLE;
          jrun_q <= jrun_q && !stop_cmd;
        end
        default: state_q <= aiq_pkg::AIQ_IDLE;
      endcase
    end
  end

  // Injected results land by their own rank, even with a stop pending
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        jres_q[i] <= 16'h0000;
      end
    end else if (cif.eoc && state_q == aiq_pkg::AIQ_CONV) begin
      jres_q[rank_q] <= cif.data;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Regular conversions and core drive
  // Regular only on its trigger; held off behind injected work
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_pending_q <= 1'b0;
      regres_q <= 16'h0000;
    end else begin
      if (reg_trig) begin
        reg_pending_q <= 1'b1;
      end else if (conv_start_q && !conv_inj_q) begin
        reg_pending_q <= 1'b0;
      end
      if (cif.eoc && state_q != aiq_pkg::AIQ_CONV
          && (overrun_mode_select || !status_q[aiq_pkg::ST_OVR_BIT])) begin
        regres_q <= cif.data;
      end
    end
  end

  // Start pulses; injected start on its trigger in WAIT, or in CONV on each rank result before the last
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      conv_start_q <= 1'b0;
      conv_chan_q <= 5'h00;
      conv_inj_q <= 1'b0;
    end else begin
      conv_start_q <= 1'b0;
      if (state_q == aiq_pkg::AIQ_WAIT && trig_hit && !stop_cmd) begin
        conv_start_q <= 1'b1;
        conv_inj_q <= 1'b1;
        conv_chan_q <= ctx_chan(ctx_q, 2'd0);
      end else if (state_q == aiq_pkg::AIQ_CONV && cif.eoc && !seq_done
                   && !stop_cmd) begin
        conv_start_q <= 1'b1;
        conv_inj_q <= 1'b1;
        conv_chan_q <= ctx_chan(ctx_q, rank_q + 2'd1);
      end else if (reg_pending_q && state_q == aiq_pkg::AIQ_IDLE
                   && !conv_start_q && (reg_trig
                   || !(dual_mode == aiq_pkg::DUAL_INTL_SIMINJ
                   || dual_mode == aiq_pkg::DUAL_INTL_ONLY))) begin
        // Interleaved modes: regular start tied to a fresh trigger
        conv_start_q <= 1'b1;
        conv_inj_q <= 1'b0;
        conv_chan_q <= cfg_q[aiq_pkg::CFG_GUARD_LSB +: 5];
      end
    end
  end

  assign cif.eoc = conv_eoc;
  assign cif.data = conv_data;
  assign cif.start = conv_start_q;
  assign cif.chan = conv_chan_q;
  assign cif.injected = conv_inj_q;

  // Watchdog guards the channel picked in config bits 20:16
  aiq_watchdog u_awd (
    .clk(clk),
    .rst_n(rst_n),
    .eoc(cif.eoc),
    .guarded(conv_chan_q == cfg_q[20:16]),
    .data(cif.data),
    .thresh(thresh_q),
    .awd_q(awd_q)
  );
  assign watchdog_out_signal = awd_q;

  //////////////////////////////////////////////////////////////////////////
  // Interrupt status: set beats clear
  assign ev[aiq_pkg::ST_INJECTED_SEQUENCE_END_FLAG_BIT] = seq_done;
  assign ev[aiq_pkg::ST_AWD_BIT] = cif.eoc && awd_q == 1'b0
                                   && conv_chan_q == cfg_q[20:16];
  assign ev[aiq_pkg::ST_QEMPTY_BIT] = q_empty && pop_req;
  assign ev[aiq_pkg::ST_OVR_BIT] = cif.eoc && state_q != aiq_pkg::AIQ_CONV;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_q <= 4'h0;
    end else begin
      status_q <= (status_q & ~((wr && addr == aiq_pkg::ADDR_IRQ_CLR)
                  ? wdata[3:0] : 4'h0)) | ev;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & irq_en_q);
    end
  end

  // Read data valid the cycle after the strobe only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd) begin
      case (addr)
        aiq_pkg::ADDR_CTRL: rdata_q <= {31'h0, jrun_q};
        aiq_pkg::ADDR_CFG: rdata_q <= cfg_q;
        aiq_pkg::ADDR_JSEQ: rdata_q <= ctx_q;
        aiq_pkg::ADDR_COMMON: rdata_q <= common_q;
        aiq_pkg::ADDR_STATUS: rdata_q <= {26'h0, q_full, q_empty, status_q};
        aiq_pkg::ADDR_IRQ_EN: rdata_q <= {28'h0, irq_en_q};
        aiq_pkg::ADDR_THRESH: rdata_q <= thresh_q;
        aiq_pkg::ADDR_REGRES: rdata_q <= {16'h0, regres_q};
        aiq_pkg::ADDR_ID: rdata_q <= aiq_pkg::ID_VALUE;
        8'h20, 8'h24, 8'h28, 8'h2c: rdata_q <= {16'h0, jres_q[addr[3:2]]};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_trig_in_wait;
    state_q == aiq_pkg::AIQ_WAIT && trig_hit && !stop_cmd;
  endsequence
  a_inj_wait_trig: assert property (@(posedge clk) disable iff (!rst_n)
    conv_start_q && conv_inj_q && $past(state_q) == aiq_pkg::AIQ_WAIT
    |-> $past(trig_hit)) else $error("injected start without trigger");
  a_trig_start: assert property (@(posedge clk) disable iff (!rst_n)
    s_trig_in_wait |=> conv_start_q && conv_inj_q)
    else $error("trigger did not start injected");
  a_seq_end_idle: assert property (@(posedge clk) disable iff (!rst_n)
    seq_done && !stop_cmd |=> state_q == aiq_pkg::AIQ_DONE ##1
    state_q == aiq_pkg::AIQ_IDLE) else $error("sequence end lost");
  a_stop_halts: assert property (@(posedge clk) disable iff (!rst_n)
    stop_cmd |=> !jrun_q) else $error("stop not obeyed");
  a_reg_needs_trig: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(reg_pending_q) |-> $past(reg_trig))
    else $error("regular pending without trigger");
  a_awd_rise: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(watchdog_out_signal) |-> $past(cif.eoc)
    && $past(conv_chan_q == cfg_q[20:16]))
    else $error("watchdog rose without guarded end");
  a_awd_hold: assert property (@(posedge clk) disable iff (!rst_n)
    cif.eoc && conv_chan_q != cfg_q[20:16] |=> $stable(awd_q))
    else $error("unguarded result moved watchdog");
  a_injected_sequence_end_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
    seq_done |=> status_q[aiq_pkg::ST_INJECTED_SEQUENCE_END_FLAG_BIT])
    else $error("sequence end flag lost");
  a_keep_last: assert property (@(posedge clk) disable iff (!rst_n)
    !queue_mode_select && !q_empty && !(wr && addr == aiq_pkg::ADDR_JSEQ)
    |=> !q_empty) else $error("queue ran dry in keep mode");
endmodule : aiq_top

// File: dv/aiq_core_model.sv
// Behavioural conversion core that answers start pulses after a set delay
`timescale 1ns/10ps
module aiq_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Requests from the sequencer
  input wire logic start,
  input wire logic [4:0] chan,
  input wire logic [3:0] lat,
  // Answers
  output logic eoc,
  output logic [15:0] data
);
  logic [3:0] cnt_q;
  logic [4:0] chan_q;

  ////////////////////////////////////////////////////////////////////////////
  // Count down the conversion time, then show the result for one cycle;
  // lat must be at least 1 or the conversion never ends
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
      chan_q <= 5'h00;
      eoc <= 1'b0;
      data <= 16'h0000;
    end else begin
      eoc <= 1'b0;
      // Stale result is inverted so it never passes for a fresh one
      data <= ~data;
      if (start) begin
        cnt_q <= lat;
        chan_q <= chan;
      end else if (cnt_q == 4'h1) begin
        cnt_q <= 4'h0;
        eoc <= 1'b1;
        data <= {3'h0, chan_q, 8'h00};
      end else if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule : aiq_core_model

// File: dv/test_aiq_top.sv
// Self-checking bench for the injected queue control block
`timescale 1ns/10ps
module test_aiq_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata_q;
  logic [15:0] inj_trig_pin = 16'h0000;
  logic reg_trig_pin = 1'b0;
  logic conv_start_q;
  logic conv_inj_q;
  logic conv_eoc;
  logic watchdog_out_signal;
  logic irq_q;
  logic [4:0] conv_chan_q;
  logic [15:0] conv_data;
  logic [3:0] lat = 4'h3;
  logic [4:0] starts[$];
  logic [31:0] v;
  int reg_cnt = 0;
  int error_cnt = 0;
  int checks = 0;
  int cycles = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Clock at 40 MHz
  always #12.5 clk = ~clk;

  aiq_top dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata_q(rdata_q), .inj_trig_pin(inj_trig_pin),
    .reg_trig_pin(reg_trig_pin), .conv_start_q(conv_start_q),
    .conv_chan_q(conv_chan_q), .conv_inj_q(conv_inj_q),
    .conv_eoc(conv_eoc), .conv_data(conv_data),
    .watchdog_out_signal(watchdog_out_signal), .irq_q(irq_q));

  aiq_core_model core (.clk(clk), .rst_n(rst_n), .start(conv_start_q),
    .chan(conv_chan_q), .lat(lat), .eoc(conv_eoc), .data(conv_data));

  // Log starts mid-cycle, away from the edge that moves them
  always @(negedge clk) begin
    if (conv_start_q === 1'b1 && conv_inj_q === 1'b1)
      starts.push_back(conv_chan_q);
    if (conv_start_q === 1'b1 && conv_inj_q === 1'b0)
      reg_cnt++;
  end

  // Cut a hang short well past the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata_q;
  endtask : rd_reg

  task automatic rd_chk(input string what, input logic [7:0] a,
                        input logic [31:0] exp);
    logic [31:0] d;
    rd_reg(a, d);
    check(what, d, exp);
  endtask : rd_chk

  task automatic chk_starts(input logic [4:0] e[$]);
    check("start count", starts.size(), e.size());
    foreach (e[i])
      if (i < starts.size())
        check("start chan", {27'h0, starts[i]}, {27'h0, e[i]});
    starts.delete();
  endtask : chk_starts

  // Context word: length-1, polarity, trigger line 0, four rank channels
  function automatic logic [31:0] ctx(input logic [1:0] len,
    input logic [1:0] pol, input logic [4:0] c1, c2, c3, c4);
    ctx = {1'b0, c4, 1'b0, c3, 1'b0, c2, 1'b0, c1, pol, 4'h0, len};
  endfunction : ctx

  function automatic logic [31:0] dat(input logic [4:0] c);
    dat = {16'h0000, 3'h0, c, 8'h00};
  endfunction : dat

  // Arm, pulse trigger line 0, wait for the sequence end flag; the next
  // trigger only comes after completion, so triggers stay spaced
  task automatic run_seq();
    int i;
    wr_reg(aiq_pkg::ADDR_IRQ_CLR, 32'h0000_000f);
    wr_reg(aiq_pkg::ADDR_CTRL, 32'h0000_0001);
    inj_trig_pin <= 16'h0001;
    repeat (4) @(posedge clk);
    inj_trig_pin <= 16'h0000;
    v = 32'h0;
    for (i = 0; i < 60 && v[aiq_pkg::ST_INJECTED_SEQUENCE_END_FLAG_BIT] !== 1'b1; i++)
      rd_reg(aiq_pkg::ADDR_STATUS, v);
    check("sequence end", v & 32'h1, 32'h1);
  endtask : run_seq

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values, identity and an unmapped place
    rd_chk("cfg", aiq_pkg::ADDR_CFG, aiq_pkg::CFG_RESET);
    rd_chk("thresh", aiq_pkg::ADDR_THRESH, aiq_pkg::THRESH_RESET);
    rd_chk("id", aiq_pkg::ADDR_ID, aiq_pkg::ID_VALUE);
    rd_chk("unmapped", 8'h3c, 32'h0000_0000);
    $display("test registers done");
    // Two ranks, results by rank, interrupt raised and cleared
    wr_reg(aiq_pkg::ADDR_IRQ_EN, 32'h0000_0001);
    wr_reg(aiq_pkg::ADDR_JSEQ, ctx(2'd1, 2'b01, 5'd3, 5'd5, 5'd0, 5'd0));
    run_seq();
    chk_starts('{5'd3, 5'd5});
    rd_chk("rank1", aiq_pkg::ADDR_JRES0, dat(5'd3));
    rd_chk("rank2", aiq_pkg::ADDR_JRES0 + 8'h04, dat(5'd5));
    check("irq set", {31'h0, irq_q}, 32'h1);
    wr_reg(aiq_pkg::ADDR_IRQ_CLR, 32'h0000_0001);
    repeat (2) @(posedge clk);
    check("irq clear", {31'h0, irq_q}, 32'h0);
    $display("test first context done");
    // Queue mode 0 keeps the consumed context in force
    run_seq();
    chk_starts('{5'd3, 5'd5});
    rd_reg(aiq_pkg::ADDR_STATUS, v);
    check("not empty", v & 32'h10, 32'h0);
    // Longer context right after completion runs whole and alone
    wr_reg(aiq_pkg::ADDR_JSEQ, ctx(2'd2, 2'b01, 5'd7, 5'd8, 5'd9, 5'd0));
    run_seq();
    chk_starts('{5'd7, 5'd8, 5'd9});
    $display("test queue order done");
    // New polarity: nothing starts before its trigger
    wr_reg(aiq_pkg::ADDR_JSEQ, ctx(2'd0, 2'b10, 5'd6, 5'd0, 5'd0, 5'd0));
    repeat (20) @(posedge clk);
    wr_reg(aiq_pkg::ADDR_CTRL, 32'h0000_0001);
    repeat (20) @(posedge clk);
    check("no early start", starts.size(), 32'h0);
    run_seq();
    chk_starts('{5'd6});
    $display("test trigger wait done");
    // Watchdog on channel 5; channel 3 unguarded
    wr_reg(aiq_pkg::ADDR_CFG, 32'h0005_0000);
    wr_reg(aiq_pkg::ADDR_THRESH, 32'h0400_0000);
    wr_reg(aiq_pkg::ADDR_JSEQ, ctx(2'd1, 2'b01, 5'd5, 5'd3, 5'd0, 5'd0));
    run_seq();
    check("wd high", {31'h0, watchdog_out_signal}, 32'h1);
    wr_reg(aiq_pkg::ADDR_THRESH, 32'h0600_0000);
    wr_reg(aiq_pkg::ADDR_JSEQ, ctx(2'd0, 2'b01, 5'd3, 5'd0, 5'd0, 5'd0));
    run_seq();
    check("wd kept", {31'h0, watchdog_out_signal}, 32'h1);
    wr_reg(aiq_pkg::ADDR_JSEQ, ctx(2'd0, 2'b01, 5'd5, 5'd0, 5'd0, 5'd0));
    run_seq();
    check("wd cleared", {31'h0, watchdog_out_signal}, 32'h0);
    starts.delete();
    $display("test watchdog done");
    // Queue mode 1 lets the queue run empty
    wr_reg(aiq_pkg::ADDR_CFG, 32'h0000_0002);
    wr_reg(aiq_pkg::ADDR_JSEQ, ctx(2'd0, 2'b01, 5'd4, 5'd0, 5'd0, 5'd0));
    run_seq();
    rd_reg(aiq_pkg::ADDR_STATUS, v);
    check("empty", v & 32'h10, 32'h10);
    // Both interleaved codes, back-to-back ranks, prompt and slow core
    wr_reg(aiq_pkg::ADDR_CFG, 32'h0000_0000);
    for (int k = 0; k < 2; k++) begin
      v = {27'h0, k == 0 ? aiq_pkg::DUAL_INTL_SIMINJ
                         : aiq_pkg::DUAL_INTL_ONLY};
      lat <= k == 0 ? 4'h1 : 4'h6;
      wr_reg(aiq_pkg::ADDR_COMMON, v);
      rd_chk("dual code", aiq_pkg::ADDR_COMMON, v);
      wr_reg(aiq_pkg::ADDR_JSEQ, ctx(2'd1, 2'b01, 5'd1, 5'd2, 5'd0, 5'd0));
      reg_cnt = 0;
      run_seq();
      repeat (10) @(posedge clk);
      check("no regular", reg_cnt, 32'h0);
    end
    // Stop only once the sequence end flag has been seen
    wr_reg(aiq_pkg::ADDR_CTRL, 32'h0000_0002);
    rd_chk("stopped", aiq_pkg::ADDR_CTRL, 32'h0000_0000);
    starts.delete();
    $display("test dual done");
    // Stop in mid-sequence keeps the first rank result in place
    wr_reg(aiq_pkg::ADDR_COMMON, 32'h0000_0000);
    lat <= 4'h8;
    wr_reg(aiq_pkg::ADDR_JSEQ, ctx(2'd3, 2'b01, 5'd1, 5'd2, 5'd3, 5'd4));
    wr_reg(aiq_pkg::ADDR_CTRL, 32'h0000_0001);
    inj_trig_pin <= 16'h0001;
    for (int i = 0; i < 100 && starts.size() < 2; i++)
      @(posedge clk);
    inj_trig_pin <= 16'h0000;
    wr_reg(aiq_pkg::ADDR_CTRL, 32'h0000_0002);
    repeat (40) @(posedge clk);
    check("halted", starts.size(), 32'h2);
    rd_chk("stop rank1", aiq_pkg::ADDR_JRES0, dat(5'd1));
    rd_chk("run bit", aiq_pkg::ADDR_CTRL, 32'h0000_0000);
    $display("test stop done");
    // Regular start on its trigger; overrun mode overwrites the result
    wr_reg(aiq_pkg::ADDR_CFG, 32'h0000_0904);
    reg_cnt = 0;
    reg_trig_pin <= 1'b1;
    repeat (20) @(posedge clk);
    reg_trig_pin <= 1'b0;
    check("regular start", reg_cnt, 32'h1);
    rd_chk("regular result", aiq_pkg::ADDR_REGRES, dat(5'd9));
    $display("test regular done");
    report_and_stop();
  end
endmodule : test_aiq_top
